/* File: include/pfm_cfg.svh */
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PFM_ADDR_W             8
`define PFM_OFF_LOCATION       8'hf1
`define PFM_OFF_ANALOG         8'hf2
`define PFM_OFF_P0_SELECT      8'hf3
`define PFM_OFF_P1_SELECT      8'hf4
`define PFM_OFF_P2_SELECT      8'hf5
`define PFM_OFF_P0_DIRECTION   8'hfd

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define PFM_RST_VALUE          8'h00
`define PFM_MASK_LOCATION      8'h73
`define PFM_MASK_P2_SELECT     8'h7f
`define PFM_RDATA_IDLE         8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define PFM_BIT_SER0_VS_SER1   6
`define PFM_BIT_SER1_VS_TMR3   5
`define PFM_BIT_TMR1_VS_TMR4   4
`define PFM_BIT_SER0_VS_TMR1   3
`define PFM_BIT_P2_PIN4_SEL    2
`define PFM_BIT_P2_PIN3_SEL    1
`define PFM_BIT_P2_PIN0_SEL    0
`define PFM_LOC_BIT_SER0       0
`define PFM_LOC_BIT_SER1       1
`define PFM_LOC_BIT_TMR4       4
`define PFM_LOC_BIT_TMR3       5
`define PFM_LOC_BIT_TMR1       6

// ****************************************************************
// Pin locations: first pin of each peripheral, pins 0-7 are port 0
// and pins 8-15 are port 1.
// ****************************************************************
`define PFM_NUM_PERIPH         5
`define PFM_NUM_PINS           16
`define PFM_PERIPH_W           4
`define PFM_PORT1_FIRST        8
`define PFM_SER0_ALT1          5'h02
`define PFM_SER0_ALT2          5'h0a
`define PFM_SER1_ALT1          5'h04
`define PFM_SER1_ALT2          5'h0c
`define PFM_TMR1_ALT1          5'h02
`define PFM_TMR1_ALT2          5'h09
`define PFM_TMR3_ALT1          5'h0b
`define PFM_TMR3_ALT2          5'h0e
`define PFM_TMR4_ALT1          5'h08
`define PFM_TMR4_ALT2          5'h0a

`endif

/* File: include/pfm_pkg.sv */
package pfm_pkg;

  // Signals of one on-chip peripheral, in its own channel order.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pfm_periph_t;

  // Peripheral index, also the fixed fallback order.
  typedef enum logic [2:0] {
    PFM_SER0,
    PFM_SER1,
    PFM_TMR1,
    PFM_TMR3,
    PFM_TMR4
  } pfm_periph_id_t;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pfm_bus_req_t;

endpackage

/* File: verilog/pfm_pin_cell.sv */
`timescale 1ns/10ps
`default_nettype none

module pfm_pin_cell
(
  input  wire logic CLK,
  input  wire logic RESET_N,
  input  wire logic sel,
  input  wire logic analog,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic per_own,
  input  wire logic per_out,
  input  wire logic per_oe,
  output var  logic pad_out,
  output var  logic pad_oe
);

  logic out_nxt;
  logic oe_nxt;

  always_comb
  begin
    out_nxt = 1'b0;
    oe_nxt  = 1'b0;
    if (analog)
    begin
      out_nxt = 1'b0;
      oe_nxt  = 1'b0;
    end
    else if (sel)
    begin
      out_nxt = per_own & per_out;
      oe_nxt  = per_own & per_oe;
    end
    else
    begin
      out_nxt = gpio_out;
      oe_nxt  = gpio_oe;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end
    else
    begin
      pad_out <= out_nxt;
      pad_oe  <= oe_nxt;
    end
  end

endmodule // pfm_pin_cell

`default_nettype wire

/* File: verilog/pfm_port_mux.sv */
// Overview of operation
// - Port 0 select register, one bit per pin.
// - Port 1 select register, one bit per pin.
// - Port 2 select bits for pins 4, 3, 0.
// - Select 0 is gpio, 1 peripheral; reset 0.
// - Bit 6: serial 0 or serial 1 wins.
// - Bit 5: serial 1 or timer 3 wins.
// - Bit 4: timer 1 or timer 4 wins.
// - Bit 3: serial 0 or timer 1 wins.
// - Priorities matter only on shared port 1 pins; reset 0.
// - Port 0 direction register, 1 is output.
// - Location bit picks alternative 1 or 2.
// - Analog input overrides port 0 select.
// - Debug use overrides port 2 pins 1, 2.
`include "pfm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module pfm_port_mux
(
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  input  wire pfm_pkg::pfm_bus_req_t BUS,
  output var  logic [7:0]          RDATA,
  input  wire logic [7:0]          P0_DATA,
  input  wire logic [7:0]          P1_DATA,
  input  wire logic [7:0]          P1_GPIO_OE,
  input  wire logic [4:0]          P2_DATA,
  input  wire logic [4:0]          P2_GPIO_OE,
  input  wire logic [4:0]          P2_PERIPH_OUT,
  input  wire logic [4:0]          P2_PERIPH_OE,
  input  wire pfm_pkg::pfm_periph_t SER0,
  input  wire pfm_pkg::pfm_periph_t SER1,
  input  wire pfm_pkg::pfm_periph_t TMR1,
  input  wire pfm_pkg::pfm_periph_t TMR3,
  input  wire pfm_pkg::pfm_periph_t TMR4,
  input  wire logic                DEBUG_ACTIVE,
  input  wire logic [1:0]          DEBUG_OUT,
  input  wire logic [1:0]          DEBUG_OE,
  output var  logic [7:0]          P0_OUT,
  output var  logic [7:0]          P0_OE,
  output var  logic [7:0]          P1_OUT,
  output var  logic [7:0]          P1_OE,
  output var  logic [4:0]          P2_OUT,
  output var  logic [4:0]          P2_OE,
  output var  logic [7:0]          P0_ANALOG
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] location_r;
  logic [7:0] analog_r;
  logic [7:0] p0_select_r;
  logic [7:0] p1_select_r;
  logic [7:0] p2_select_r;
  logic [7:0] p0_direction_r;
  logic [7:0] rdata_nxt;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      location_r <= `PFM_RST_VALUE;
    else if (BUS.wr && BUS.addr == `PFM_OFF_LOCATION)
      location_r <= BUS.wdata & `PFM_MASK_LOCATION;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      analog_r <= `PFM_RST_VALUE;
    else if (BUS.wr && BUS.addr == `PFM_OFF_ANALOG)
      analog_r <= BUS.wdata;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      p0_select_r <= `PFM_RST_VALUE;
    else if (BUS.wr && BUS.addr == `PFM_OFF_P0_SELECT)
      p0_select_r <= BUS.wdata;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      p1_select_r <= `PFM_RST_VALUE;
    else if (BUS.wr && BUS.addr == `PFM_OFF_P1_SELECT)
      p1_select_r <= BUS.wdata;
  end

  // port 2 select, top bit zero
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      p2_select_r <= `PFM_RST_VALUE;
    else if (BUS.wr && BUS.addr == `PFM_OFF_P2_SELECT)
      p2_select_r <= BUS.wdata & `PFM_MASK_P2_SELECT;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      p0_direction_r <= `PFM_RST_VALUE;
    else if (BUS.wr && BUS.addr == `PFM_OFF_P0_DIRECTION)
      p0_direction_r <= BUS.wdata;
  end

  // Unmapped addresses and idle cycles read as zero.
  always_comb
  begin
    rdata_nxt = `PFM_RDATA_IDLE;
    if (BUS.rd)
    begin
      case (BUS.addr)
        `PFM_OFF_LOCATION:     rdata_nxt = location_r;
        `PFM_OFF_ANALOG:       rdata_nxt = analog_r;
        `PFM_OFF_P0_SELECT:    rdata_nxt = p0_select_r;
        `PFM_OFF_P1_SELECT:    rdata_nxt = p1_select_r;
        `PFM_OFF_P2_SELECT:    rdata_nxt = p2_select_r;
        `PFM_OFF_P0_DIRECTION: rdata_nxt = p0_direction_r;
        default:               rdata_nxt = `PFM_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RDATA <= `PFM_RDATA_IDLE;
    else
      RDATA <= rdata_nxt;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      P0_ANALOG <= `PFM_RST_VALUE;
    else
      P0_ANALOG <= analog_r;
  end

  // ****************************************************************
  // Peripheral placement
  // ****************************************************************
  pfm_pkg::pfm_periph_t per_sig [`PFM_NUM_PERIPH];
  logic [4:0]           per_base [`PFM_NUM_PERIPH];
  logic [`PFM_NUM_PINS-1:0] claim [`PFM_NUM_PERIPH];

  assign per_sig[0] = SER0;
  assign per_sig[1] = SER1;
  assign per_sig[2] = TMR1;
  assign per_sig[3] = TMR3;
  assign per_sig[4] = TMR4;

  assign per_base[0] = location_r[`PFM_LOC_BIT_SER0] ? `PFM_SER0_ALT2 : `PFM_SER0_ALT1;
  assign per_base[1] = location_r[`PFM_LOC_BIT_SER1] ? `PFM_SER1_ALT2 : `PFM_SER1_ALT1;
  assign per_base[2] = location_r[`PFM_LOC_BIT_TMR1] ? `PFM_TMR1_ALT2 : `PFM_TMR1_ALT1;
  assign per_base[3] = location_r[`PFM_LOC_BIT_TMR3] ? `PFM_TMR3_ALT2 : `PFM_TMR3_ALT1;
  assign per_base[4] = location_r[`PFM_LOC_BIT_TMR4] ? `PFM_TMR4_ALT2 : `PFM_TMR4_ALT1;

  // A peripheral claims the pins of its location whether or not it
  // drives them, so an input channel still keeps its pin.
  always_comb
  begin
    for (int k = 0; k < `PFM_NUM_PERIPH; k++)
    begin
      for (int p = 0; p < `PFM_NUM_PINS; p++)
      begin
        claim[k][p] = (5'(p) >= per_base[k]) &&
                      (5'(p) < per_base[k] + 5'(`PFM_PERIPH_W));
      end
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // True when peripheral a takes a shared pin from peripheral b.
  function automatic logic beats(input int a, input int b, input logic port1,
                                 input logic [7:0] pri);
    logic res;
    res = (a < b);
    if (port1)
    begin
      if ((a == 0 && b == 1) || (a == 1 && b == 0))
        res = pri[`PFM_BIT_SER0_VS_SER1] ? (a == 1) : (a == 0);
      if ((a == 1 && b == 3) || (a == 3 && b == 1))
        res = pri[`PFM_BIT_SER1_VS_TMR3] ? (a == 3) : (a == 1);
      if ((a == 2 && b == 4) || (a == 4 && b == 2))
        res = pri[`PFM_BIT_TMR1_VS_TMR4] ? (a == 4) : (a == 2);
      if ((a == 0 && b == 2) || (a == 2 && b == 0))
        res = pri[`PFM_BIT_SER0_VS_TMR1] ? (a == 2) : (a == 0);
    end
    return res;
  endfunction

  logic [`PFM_NUM_PINS-1:0] own;
  logic [`PFM_NUM_PINS-1:0] own_out;
  logic [`PFM_NUM_PINS-1:0] own_oe;

  // priorities act on shared port 1 pins only
  always_comb
  begin
    logic [`PFM_NUM_PERIPH-1:0] alive;
    logic                       found;
    logic [4:0]                 off;
    int                         win;
    alive   = '0;
    found   = 1'b0;
    off     = 5'h00;
    win     = 0;
    own     = '0;
    own_out = '0;
    own_oe  = '0;
    for (int p = 0; p < `PFM_NUM_PINS; p++)
    begin
      found = 1'b0;
      win   = 0;
      for (int k = 0; k < `PFM_NUM_PERIPH; k++)
      begin
        alive[k] = claim[k][p];
        for (int j = 0; j < `PFM_NUM_PERIPH; j++)
        begin
          if (j != k && claim[j][p] &&
              beats(j, k, p >= `PFM_PORT1_FIRST, p2_select_r))
            alive[k] = 1'b0;
        end
      end
      // Circular priority settings could leave no survivor; the fixed
      // order then breaks the tie rather than leave the pin idle.
      for (int k = `PFM_NUM_PERIPH - 1; k >= 0; k--)
      begin
        if (claim[k][p])
        begin
          found = 1'b1;
          win   = k;
        end
      end
      for (int k = `PFM_NUM_PERIPH - 1; k >= 0; k--)
      begin
        if (alive[k])
          win = k;
      end
      off        = 5'(p) - per_base[win];
      own[p]     = found;
      own_out[p] = found & per_sig[win].out[off[1:0]];
      own_oe[p]  = found & per_sig[win].oe[off[1:0]];
    end
  end

  // ****************************************************************
  // Pin cells
  // ****************************************************************
  genvar g;

  generate
    for (g = 0; g < 8; g++)
    begin : gen_p0
      pfm_pin_cell u_cell
      (
        .CLK      (CLK),
        .RESET_N  (RESET_N),
        .sel      (p0_select_r[g]),
        .analog   (analog_r[g]),
        .gpio_out (P0_DATA[g]),
        .gpio_oe  (p0_direction_r[g]),
        .per_own  (own[g]),
        .per_out  (own_out[g]),
        .per_oe   (own_oe[g]),
        .pad_out  (P0_OUT[g]),
        .pad_oe   (P0_OE[g])
      );
    end

    for (g = 0; g < 8; g++)
    begin : gen_p1
      pfm_pin_cell u_cell
      (
        .CLK      (CLK),
        .RESET_N  (RESET_N),
        .sel      (p1_select_r[g]),
        .analog   (1'b0),
        .gpio_out (P1_DATA[g]),
        .gpio_oe  (P1_GPIO_OE[g]),
        .per_own  (own[g + `PFM_PORT1_FIRST]),
        .per_out  (own_out[g + `PFM_PORT1_FIRST]),
        .per_oe   (own_oe[g + `PFM_PORT1_FIRST]),
        .pad_out  (P1_OUT[g]),
        .pad_oe   (P1_OE[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Port 2
  // ****************************************************************
  logic [4:0] p2_sel;
  logic [4:0] p2_gpio_out;
  logic [4:0] p2_gpio_oe;

  assign p2_sel[0] = p2_select_r[`PFM_BIT_P2_PIN0_SEL];
  assign p2_sel[1] = 1'b0;
  assign p2_sel[2] = 1'b0;
  assign p2_sel[3] = p2_select_r[`PFM_BIT_P2_PIN3_SEL];
  assign p2_sel[4] = p2_select_r[`PFM_BIT_P2_PIN4_SEL];

  // debug owns pins 1 and 2
  assign p2_gpio_out = DEBUG_ACTIVE ? {P2_DATA[4:3], DEBUG_OUT[1:0], P2_DATA[0]} : P2_DATA;
  assign p2_gpio_oe  = DEBUG_ACTIVE ? {P2_GPIO_OE[4:3], DEBUG_OE[1:0], P2_GPIO_OE[0]}
                                    : P2_GPIO_OE;

  generate
    for (g = 0; g < 5; g++)
    begin : gen_p2
      pfm_pin_cell u_cell
      (
        .CLK      (CLK),
        .RESET_N  (RESET_N),
        .sel      (p2_sel[g]),
        .analog   (1'b0),
        .gpio_out (p2_gpio_out[g]),
        .gpio_oe  (p2_gpio_oe[g]),
        .per_own  (1'b1),
        .per_out  (P2_PERIPH_OUT[g]),
        .per_oe   (P2_PERIPH_OE[g]),
        .pad_out  (P2_OUT[g]),
        .pad_oe   (P2_OE[g])
      );
    end
  endgenerate

endmodule // pfm_port_mux

`default_nettype wire

/* File: dv/pfm_port_mux_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

module pfm_port_mux_assertions
(
  input wire logic                  CLK,
  input wire logic                  RESET_N,
  input wire pfm_pkg::pfm_bus_req_t BUS,
  input wire logic [7:0]            RDATA,
  input wire logic [7:0]            P0_DATA,
  input wire logic [7:0]            P1_GPIO_OE,
  input wire logic                  DEBUG_ACTIVE,
  input wire logic [1:0]            DEBUG_OE,
  input wire logic [7:0]            P0_OUT,
  input wire logic [7:0]            P0_OE,
  input wire logic [7:0]            P1_OE,
  input wire logic [4:0]            P2_OE,
  input wire logic [7:0]            P0_ANALOG
);
  // Shadow copies of the selects, so pad checks need no view inside.
  logic [7:0] s0_r;
  logic [7:0] s1_r;
  logic [7:0] d0_r;
  logic [7:0] an_r;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s0_r <= 8'h00;
      s1_r <= 8'h00;
      d0_r <= 8'h00;
      an_r <= 8'h00;
    end
    else if (BUS.wr)
    begin
      if (BUS.addr == 8'hf2) an_r <= BUS.wdata;
      if (BUS.addr == 8'hf3) s0_r <= BUS.wdata;
      if (BUS.addr == 8'hf4) s1_r <= BUS.wdata;
      if (BUS.addr == 8'hfd) d0_r <= BUS.wdata;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence wr_sel_s;
    BUS.wr && BUS.addr inside {8'hf3, 8'hf4, 8'hfd};
  endsequence
  sequence rd_same_s;
    BUS.rd && BUS.addr == $past(BUS.addr);
  endsequence

  rst_outputs_zero_a: assert property ($rose(RESET_N) |-> (P0_OE | P1_OE) == 8'h00)
    else $error("pad enable set right after reset");
  rd_idle_a: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
    else $error("read data outside the read slot");
  sel_readback_a: assert property (wr_sel_s ##1 rd_same_s |=> RDATA == $past(BUS.wdata, 2))
    else $error("register read back differs from write");
  unmapped_rd_a: assert property (BUS.rd && !(BUS.addr inside {[8'hf1:8'hf5], 8'hfd})
    |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  p2_reserved_a: assert property (BUS.rd && BUS.addr == 8'hf5 |=> !RDATA[7])
    else $error("unused select bit reads one");
  analog_wins_a: assert property ((P0_ANALOG & $past(P0_ANALOG) & (P0_OE | P0_OUT)) == 8'h00)
    else $error("analog pin still driven");
  gpio_p0_a: assert property ((~$past(s0_r | an_r) & ((P0_OE ^ $past(d0_r))
    | ($past(d0_r) & (P0_OUT ^ $past(P0_DATA))))) == 8'h00)
    else $error("port 0 gpio pin wrong");
  gpio_p1_a: assert property ((~$past(s1_r) & (P1_OE ^ $past(P1_GPIO_OE))) == 8'h00)
    else $error("port 1 gpio enable wrong");
  debug_pins_a: assert property ($past(RESET_N) && $past(DEBUG_ACTIVE)
    |-> P2_OE[2:1] == $past(DEBUG_OE))
    else $error("debug pins not handed over");
endmodule // pfm_port_mux_assertions

bind pfm_port_mux pfm_port_mux_assertions u_chk (.*);

`default_nettype wire

/* File: dv/pfm_periph_model.sv */
`timescale 1ns/10ps
`default_nettype none

module pfm_periph_model
(
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  output var  pfm_pkg::pfm_periph_t SER0,
  output var  pfm_pkg::pfm_periph_t SER1,
  output var  pfm_pkg::pfm_periph_t TMR1,
  output var  pfm_pkg::pfm_periph_t TMR3,
  output var  pfm_pkg::pfm_periph_t TMR4
);
  // The units follow a 40-bit LFSR that shifts every cycle, so a pad showing the wrong owner shows.
  logic [39:0] lfsr_r;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      lfsr_r <= 40'h3c_5a96_e1d7;
    else
      lfsr_r <= {lfsr_r[38:0], lfsr_r[39] ^ lfsr_r[37] ^ lfsr_r[20] ^ lfsr_r[18]};
  end

  assign {SER0, SER1, TMR1, TMR3, TMR4} = lfsr_r;
endmodule // pfm_periph_model

`default_nettype wire

/* File: dv/pfm_port_mux_test.sv */
`timescale 1ns/10ps
`default_nettype none

module pfm_port_mux_test;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  pfm_pkg::pfm_bus_req_t bus = '0;
  logic [7:0]            p0_data = '0, p1_data = '0, p1_gpio_oe = '0;
  logic [4:0]            p2_data = '0, p2_gpio_oe = '0, p2_periph_out = '0, p2_periph_oe = '0;
  logic                  dbg_act = 1'b0;
  logic [1:0]            dbg_out = '0, dbg_oe = '0;
  logic [7:0]            rdata, p0_out, p0_oe, p1_out, p1_oe, p0_analog, rexp;
  logic [4:0]            p2_out, p2_oe, exp2_o = '0, exp2_e = '0;
  logic [15:0]           exp_o = '0, exp_e = '0;
  logic                  rchk = 1'b0;
  pfm_pkg::pfm_periph_t  per [5];
  logic [7:0]            sh [6] = '{default: 8'h00};
  logic [7:0]            exp_an = '0;
  logic [7:0]            am [6] = '{8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hfd};
  logic [7:0]            mk [6] = '{8'h73, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff};
  logic [7:0]            lc [4] = '{8'h03, 8'h02, 8'h40, 8'h41};
  int                    lb [5] = '{0, 1, 6, 5, 4};
  int                    b1 [5] = '{2, 4, 2, 11, 8};
  int                    b2 [5] = '{10, 12, 9, 14, 10};
  int                    bad_count = 0, comparisons = 0, cyc = 0, r;

  pfm_port_mux u_dut (.CLK(clk), .RESET_N(reset_n), .BUS(bus), .RDATA(rdata),
    .P0_DATA(p0_data), .P1_DATA(p1_data), .P1_GPIO_OE(p1_gpio_oe), .P2_DATA(p2_data),
    .P2_GPIO_OE(p2_gpio_oe), .P2_PERIPH_OUT(p2_periph_out), .P2_PERIPH_OE(p2_periph_oe),
    .SER0(per[0]), .SER1(per[1]), .TMR1(per[2]), .TMR3(per[3]), .TMR4(per[4]),
    .DEBUG_ACTIVE(dbg_act), .DEBUG_OUT(dbg_out), .DEBUG_OE(dbg_oe), .P0_OUT(p0_out),
    .P0_OE(p0_oe), .P1_OUT(p1_out), .P1_OE(p1_oe), .P2_OUT(p2_out), .P2_OE(p2_oe),
    .P0_ANALOG(p0_analog));
  pfm_periph_model u_per (.CLK(clk), .RESET_N(reset_n), .SER0(per[0]), .SER1(per[1]),
    .TMR1(per[2]), .TMR3(per[3]), .TMR4(per[4]));

  // ********************
  // Reference model
  // ********************
  function automatic int idx(logic [7:0] a);
    for (int i = 0; i < 6; i++)
      if (am[i] == a)
        return i;
    return -1;
  endfunction
  function automatic int base(int a);
    return sh[0][lb[a]] ? b2[a] : b1[a];
  endfunction
  // Port 0 overlaps and unpaired units fall back to the fixed order.
  function automatic bit beats(int a, int b, int i);
    int k;
    case ((a < b ? a : b) * 8 + (a < b ? b : a))
      1: k = 6;
      11: k = 5;
      20: k = 4;
      2: k = 3;
      default: k = -1;
    endcase
    if (i < 8 || k < 0)
      return a < b;
    return sh[4][k] == (a > b);
  endfunction

  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      sh <= '{default: 8'h00};
    else if (bus.wr && idx(bus.addr) >= 0)
      sh[idx(bus.addr)] <= bus.wdata & mk[idx(bus.addr)];

  always @(posedge clk)
  begin : predict
    int w, f;
    logic ok, po, pe, sl;
    logic [15:0] eo, ee;
    logic [4:0] s2, o2, e2;
    for (int i = 0; i < 16; i++)
    begin
      w = -1;
      f = -1;
      for (int a = 0; a < 5; a++)
        if (i >= base(a) && i < base(a) + 4)
        begin
          ok = 1'b1;
          for (int b = 0; b < 5; b++)
            if (b != a && i >= base(b) && i < base(b) + 4 && !beats(a, b, i))
              ok = 1'b0;
          if (f < 0)
            f = a;
          if (ok && w < 0)
            w = a;
        end
      if (w < 0)
        w = f;
      po = w >= 0 ? per[w].out[i - base(w)] : 1'b0;
      pe = w >= 0 ? per[w].oe[i - base(w)] : 1'b0;
      sl = i < 8 ? sh[2][i] : sh[3][i - 8];
      eo[i] = sl ? po : i < 8 ? p0_data[i] : p1_data[i - 8];
      ee[i] = sl ? pe : i < 8 ? sh[5][i] : p1_gpio_oe[i - 8];
      if (i < 8 && sh[1][i])
        ee[i] = 1'b0;
    end
    s2 = {sh[4][2], sh[4][1], 2'b00, sh[4][0]};
    o2 = (s2 & p2_periph_out) | (~s2 & p2_data);
    e2 = (s2 & p2_periph_oe) | (~s2 & p2_gpio_oe);
    if (dbg_act)
    begin
      o2[2:1] = dbg_out;
      e2[2:1] = dbg_oe;
    end
    exp_o <= eo;
    exp_e <= ee;
    exp2_o <= o2;
    exp2_e <= e2;
    exp_an <= sh[1];
    rchk <= bus.rd;
    rexp <= idx(bus.addr) < 0 ? 8'h00 : sh[idx(bus.addr)];
  end

  task automatic chk(logic [7:0] g, logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  always @(negedge clk)
  begin
    chk(p0_oe, exp_e[7:0]);
    chk(p0_out & exp_e[7:0], exp_o[7:0] & exp_e[7:0]);
    chk(p1_oe, exp_e[15:8]);
    chk(p1_out & exp_e[15:8], exp_o[15:8] & exp_e[15:8]);
    chk({3'h0, p2_oe}, {3'h0, exp2_e});
    chk({3'h0, p2_out & exp2_e}, {3'h0, exp2_o & exp2_e});
    chk(rdata, rchk ? rexp : 8'h00);
    chk(p0_analog, exp_an);
  end

  // ********************
  // Stimulus
  // ********************
  task automatic op(logic [1:0] k, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: k[1], rd: k[0]};
    {p0_data, p1_data, p1_gpio_oe} <= 24'($urandom);
    {p2_data, p2_gpio_oe, p2_periph_out, p2_periph_oe} <= 20'($urandom);
    {dbg_act, dbg_out, dbg_oe} <= 5'($urandom);
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    forever #25 clk = ~clk;
  end

  // A hung run is cut off well beyond the roughly 3070 cycles used.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(92));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 7; k++)
      op(2'b01, k < 6 ? am[k] : 8'h80, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      op(2'b10, 8'hf1, lc[k]);
      op(2'b10, 8'hf4, 8'hff);
      op(2'b10, 8'hf5, 8'h40 >> k);
      repeat (3) op(2'b00, 8'h00, 8'h00);
      op(2'b10, 8'hf5, 8'h00);
      repeat (3) op(2'b00, 8'h00, 8'h00);
    end
    for (int n = 0; n < 3000; n++)
    begin
      r = $urandom % 8;
      op(r < 4 ? 2'b10 : r < 6 ? 2'b01 : 2'b00,
         r % 4 == 3 ? 8'($urandom) : am[$urandom % 6], 8'($urandom));
    end
    repeat (3) op(2'b00, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule // pfm_port_mux_test

`default_nettype wire
